// ---- hdl/mii_port_regs.vh ----
// Constants for the external MII port multiplexer
`ifndef MII_PORT_REGS_VH
`define MII_PORT_REGS_VH
// Nibble width of the MII data paths
`define MII_NIB_W            4
// Idle level of parked outputs
`define MII_PARK_NIB         4'h0
`define MII_PARK_BIT         1'b0
// Reset value of the strap capture
`define MII_STRAP_RST        1'b0
// Strap counter value at which the strap is sampled after reset release
`define MII_STRAP_HOLD_CYC   4'h3
// Local clock rate in kHz
`define MII_MCLK_KHZ         25000
// Management clock half period in local clocks
`define MII_MDC_HALF_CYC     8'h05
`endif

// ---- hdl/nib_buf2.v ----
// Two-entry valid/ready buffer for transmit and receive nibbles
`timescale 1ns/1ns
module nib_buf2 #(
    parameter W = 5
) (
    input  wire         mclk,
    input  wire         nrst,
    input  wire         ce,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    output wire [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);
    reg [W-1:0] mem_q [0:1];
    reg [W-1:0] head_q;
    reg         wp_q;
    reg         rp_q;
    reg [1:0]   cnt_q;
    reg         ready_q;
    reg         valid_q;
    wire        push;
    wire        pop;
    wire        rp_d;
    wire [1:0]  cnt_d;

    // Handshake flags and head word come straight from flops
    assign in_ready  = ready_q;
    assign out_valid = valid_q;
    assign out_data  = head_q;
    assign push      = in_valid & ready_q;
    assign pop       = valid_q & out_ready;
    assign rp_d      = pop ? ~rp_q : rp_q;
    // Fill level after this edge; push and pop together leave it alone
    assign cnt_d     = (push & ~pop) ? cnt_q + 2'h1 :
                       (pop & ~push) ? cnt_q - 2'h1 : cnt_q;

    // ---------------------------------------------
    // Storage and pointers
    // ---------------------------------------------
    always @(posedge mclk) begin
        if (!nrst) begin
            wp_q    <= 1'b0;
            rp_q    <= 1'b0;
            cnt_q   <= 2'h0;
            ready_q <= 1'b1;
            valid_q <= 1'b0;
            head_q  <= {W{1'b0}};
        end else if (ce) begin
            if (push) begin
                mem_q[wp_q] <= in_data;
                wp_q        <= ~wp_q;
            end
            rp_q    <= rp_d;
            cnt_q   <= cnt_d;
            ready_q <= (cnt_d != 2'h2);
            valid_q <= (cnt_d != 2'h0);
            // Word just written becomes the head when it lands at the read slot
            head_q  <= (push && (wp_q == rp_d)) ? in_data : mem_q[rp_d];
        end
    end
endmodule // nib_buf2

// ---- hdl/mii_port_mux.v ----
// External MII and management port pin multiplexer
`timescale 1ns/1ns
`include "mii_port_regs.vh"
module mii_port_mux (
    input  wire       mclk,
    input  wire       nrst,
    input  wire       ce,
    input  wire       ext_phy_sel,
    input  wire       mgmt_port_select,
    // MAC transmit stream
    input  wire [3:0] mac_tx_data,
    input  wire       mac_tx_valid,
    output wire       mac_tx_ready,
    // MAC receive stream
    output wire [3:0] mac_rx_data,
    output wire       mac_rx_valid,
    input  wire       mac_rx_ready,
    output reg        mac_rx_err,
    output reg        mac_crs,
    output reg        mac_col,
    // MAC management side
    input  wire       mac_mgmt_out,
    input  wire       mac_mgmt_oe,
    output reg        mac_mgmt_in,
    output reg        ext_phy_present_strap,
    // PHY pins
    input  wire       phy_tx_clk,
    output reg  [3:0] phy_txd,
    output reg        phy_tx_en,
    input  wire       phy_rx_clk,
    input  wire [3:0] phy_rxd,
    input  wire       phy_rx_dv,
    input  wire       phy_rx_er,
    input  wire       phy_crs,
    input  wire       phy_col,
    output reg        phy_mdc,
    input  wire       phy_mdio_in,
    output reg        phy_mdio_out,
    output reg        phy_mdio_oe
);
    // -------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------
    reg  [10:0] s1_q;
    reg  [10:0] s2_q;
    reg         txc_d1_q;
    reg         rxc_d1_q;
    wire        tx_rise;
    wire        rx_rise;

    // Two flops on every pin input
    // Bit order: 0 tx clk, 1 rx clk, 5:2 rxd, 6 dv, 7 er, 8 crs, 9 col, 10 mdio
    // Only the second stage feeds logic; the first may still be settling
    always @(posedge mclk) begin
        if (!nrst) begin
            s1_q <= 11'h000;
            s2_q <= 11'h000;
        end else if (ce) begin
            s1_q <= {phy_mdio_in, phy_col, phy_crs, phy_rx_er, phy_rx_dv, phy_rxd, phy_rx_clk, phy_tx_clk};
            s2_q <= s1_q;
        end
    end

    // Edge finders on the synchronised line clocks
    always @(posedge mclk) begin
        if (!nrst) begin
            txc_d1_q <= 1'b0;
            rxc_d1_q <= 1'b0;
        end else if (ce) begin
            txc_d1_q <= s2_q[0];
            rxc_d1_q <= s2_q[1];
        end
    end
    // Transmit data launches on the line clock fall so the PHY,
    // which samples on the rise, sees half a period of set-up;
    // the sync delay of three local clocks eats into that half
    // period, so the line clock must stay well below the local one
    assign tx_rise = txc_d1_q & ~s2_q[0];
    assign rx_rise = s2_q[1] & ~rxc_d1_q;

    // -------------------------------------------------
    // Transmit path
    // -------------------------------------------------
    wire [3:0] tx_b_data;
    wire       tx_b_valid;
    wire       tx_take;

    // Two-entry buffer decouples the MAC from the line clock
    nib_buf2 #(.W(4)) u_tx_buf (
        .mclk      (mclk),
        .nrst      (nrst),
        .ce        (ce),
        .in_data   (mac_tx_data),
        .in_valid  (mac_tx_valid),
        .in_ready  (mac_tx_ready),
        .out_data  (tx_b_data),
        .out_valid (tx_b_valid),
        .out_ready (tx_take)
    );
    assign tx_take = ext_phy_sel & tx_rise;

    // Drive one nibble per transmit clock; parked when internal PHY used
    always @(posedge mclk) begin
        if (!nrst) begin
            phy_txd   <= `MII_PARK_NIB;
            phy_tx_en <= `MII_PARK_BIT;
        end else if (ce) begin
            if (!ext_phy_sel) begin
                phy_txd   <= `MII_PARK_NIB;
                phy_tx_en <= `MII_PARK_BIT;
            end else if (tx_rise) begin
                phy_txd   <= tx_b_valid ? tx_b_data : `MII_PARK_NIB;
                phy_tx_en <= tx_b_valid;
            end
        end
    end

    // -------------------------------------------------
    // Receive path
    // -------------------------------------------------
    wire rx_push;
    wire [4:0] rx_b_data;

    // Sample nibble plus error on each receive clock rise while valid
    assign rx_push = ext_phy_sel & rx_rise & s2_q[6];

    // A nibble that finds the buffer full is dropped; the line cannot wait
    nib_buf2 #(.W(5)) u_rx_buf (
        .mclk      (mclk),
        .nrst      (nrst),
        .ce        (ce),
        .in_data   ({s2_q[7], s2_q[5:2]}),
        .in_valid  (rx_push),
        .in_ready  (),
        .out_data  (rx_b_data),
        .out_valid (mac_rx_valid),
        .out_ready (mac_rx_ready)
    );
    assign mac_rx_data = rx_b_data[3:0];

    // Status levels toward the MAC
    // Forced low with the internal PHY so the MAC sees a quiet line
    always @(posedge mclk) begin
        if (!nrst) begin
            mac_rx_err <= 1'b0;
            mac_crs    <= 1'b0;
            mac_col    <= 1'b0;
        end else if (ce) begin
            mac_rx_err <= ext_phy_sel & s2_q[7];
            mac_crs    <= ext_phy_sel & s2_q[8];
            mac_col    <= ext_phy_sel & s2_q[9];
        end
    end

    // -------------------------------------------------
    // Strap capture and management port
    // -------------------------------------------------
    reg [3:0] strap_cnt_q;
    reg       strap_done_q;
    reg [7:0] mdc_cnt_q;

    // Strap sampled once, on the fourth clock after reset release, before any drive
    // The pin is undriven here, so the board strap sets its level
    always @(posedge mclk) begin
        if (!nrst) begin
            strap_cnt_q           <= 4'h0;
            strap_done_q          <= 1'b0;
            ext_phy_present_strap <= `MII_STRAP_RST;
        end else if (ce && !strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 4'h1;
            if (strap_cnt_q == `MII_STRAP_HOLD_CYC) begin
                ext_phy_present_strap <= s2_q[10];
                strap_done_q          <= 1'b1;
            end
        end
    end

    // Management clock divider and data pin steering
    // Pins stay parked until the strap is taken so the strap is read clean
    always @(posedge mclk) begin
        if (!nrst) begin
            mdc_cnt_q    <= 8'h00;
            phy_mdc      <= 1'b0;
            phy_mdio_out <= 1'b0;
            phy_mdio_oe  <= 1'b0;
            mac_mgmt_in  <= 1'b0;
        end else if (ce) begin
            mac_mgmt_in <= s2_q[10];
            if (mgmt_port_select && strap_done_q) begin
                if (mdc_cnt_q == `MII_MDC_HALF_CYC - 8'h01) begin
                    mdc_cnt_q <= 8'h00;
                    phy_mdc   <= ~phy_mdc;
                end else
                    mdc_cnt_q <= mdc_cnt_q + 8'h01;
                phy_mdio_out <= mac_mgmt_out;
                phy_mdio_oe  <= mac_mgmt_oe;
            end else begin
                mdc_cnt_q    <= 8'h00;
                phy_mdc      <= 1'b0;
                phy_mdio_out <= 1'b0;
                phy_mdio_oe  <= 1'b0;
            end
        end
    end
endmodule // mii_port_mux

// ---- dv/mii_port_assertions.sv ----
// Checker for the MII port multiplexer pins
`timescale 1ns/1ns
module mii_port_assertions (
    input wire       mclk,
    input wire       nrst,
    input wire       ext_phy_sel,
    input wire       mgmt_port_select,
    input wire       mac_mgmt_out,
    input wire [3:0] phy_txd,
    input wire       phy_tx_en,
    input wire       phy_mdc,
    input wire       phy_mdio_out,
    input wire       phy_mdio_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ----
    // Pin rules
    // ----
    txd_park_a: assert property ((!ext_phy_sel)[*2] |-> phy_txd == 4'h0)
        else $error("txd not parked");
    txen_park_a: assert property ((!ext_phy_sel)[*2] |-> !phy_tx_en)
        else $error("tx_en not parked");
    txen_data_a: assert property (!phy_tx_en |-> phy_txd == 4'h0)
        else $error("txd without tx_en");
    mdio_hiz_a: assert property ((!mgmt_port_select)[*2] |-> !phy_mdio_oe)
        else $error("mdio driven");
    mdc_off_a: assert property ((!mgmt_port_select)[*2] |-> !phy_mdc)
        else $error("mdc not low");
    mdio_follow_a: assert property (phy_mdio_oe |-> phy_mdio_out == $past(mac_mgmt_out))
        else $error("mdio out lags");
    mdc_high_a: assert property (disable iff (!nrst || !mgmt_port_select)
        $rose(phy_mdc) |-> phy_mdc[*5] ##1 !phy_mdc) else $error("mdc high time");
    mdc_low_a: assert property (disable iff (!nrst || !mgmt_port_select)
        $fell(phy_mdc) |-> (!phy_mdc)[*5] ##1 phy_mdc) else $error("mdc low time");
    strap_park_a: assert property ($rose(nrst) |-> (!phy_mdio_oe && !phy_mdc)[*4])
        else $error("pin driven before strap");
    // Main scenarios
    cover property ($rose(phy_tx_en));
    cover property ($rose(phy_mdio_oe));
    cover property ($rose(phy_mdc));
endmodule // mii_port_assertions

// ---- dv/mii_phy_model.sv ----
// Behavioural external PHY on the MII pins
`timescale 1ns/1ns
module mii_phy_model (
    input  wire       phy_tx_en,
    input  wire [3:0] phy_txd,
    input  wire       phy_mdio_out,
    input  wire       phy_mdio_oe,
    output reg        phy_tx_clk = 1'b0,
    output reg        phy_rx_clk = 1'b1,
    output reg  [3:0] phy_rxd = 4'h0,
    output reg        phy_rx_dv = 1'b0,
    output reg        phy_rx_er = 1'b0,
    output reg        phy_crs = 1'b0,
    output reg        phy_col = 1'b0,
    output wire       phy_mdio_in
);
    logic       strap = 1'b0;
    logic [3:0] got[$];
    // Line clocks with a 320 ns period (3.125 MHz), free running
    always #160 phy_tx_clk = ~phy_tx_clk;
    always #160 phy_rx_clk = ~phy_rx_clk;
    // Pin level: driven value, else pull-down or strap
    assign phy_mdio_in = phy_mdio_oe ? phy_mdio_out : strap;
    // Line takes nibbles on the rising tx clock
    always @(posedge phy_tx_clk) if (phy_tx_en) got.push_back(phy_txd);
    // One received nibble, data scrambled once invalid
    task rx_nib(input logic [3:0] d);
        @(negedge phy_rx_clk);
        phy_rxd = d;
        phy_rx_dv = 1'b1;
        @(negedge phy_rx_clk);
        phy_rxd = ~d;
        phy_rx_dv = 1'b0;
    endtask
endmodule // mii_phy_model

// ---- dv/testbench.sv ----
// Self-checking bench for the MII port multiplexer
`timescale 1ns/1ns
module testbench;
    logic mclk = 0, nrst = 0, ext_phy_sel = 0, mgmt_port_select = 0, mac_tx_valid = 0;
    logic mac_rx_ready = 0, mac_mgmt_out = 0, mac_mgmt_oe = 0;
    logic ce = 1, mdc_was = 0;
    logic [3:0] mac_tx_data = 4'h0;
    wire  [3:0] mac_rx_data, phy_txd, phy_rxd;
    wire  mac_tx_ready, mac_rx_valid, mac_rx_err, mac_crs, mac_col, mac_mgmt_in, ext_phy_present_strap;
    wire  phy_tx_clk, phy_tx_en, phy_rx_clk, phy_rx_dv, phy_rx_er, phy_crs, phy_col, phy_mdc;
    wire  phy_mdio_in, phy_mdio_out, phy_mdio_oe;
    int   bad_count = 0, n_compared = 0, cyc = 0, i;
    logic [7:0] rows[4] = '{8'h11, 8'h88, 8'hff, 8'h00};
    mii_port_mux DUT (.mclk, .nrst, .ce, .ext_phy_sel, .mgmt_port_select, .mac_tx_data,
        .mac_tx_valid, .mac_tx_ready, .mac_rx_data, .mac_rx_valid, .mac_rx_ready, .mac_rx_err,
        .mac_crs, .mac_col, .mac_mgmt_out, .mac_mgmt_oe, .mac_mgmt_in, .ext_phy_present_strap,
        .phy_tx_clk, .phy_txd, .phy_tx_en, .phy_rx_clk, .phy_rxd, .phy_rx_dv, .phy_rx_er,
        .phy_crs, .phy_col, .phy_mdc, .phy_mdio_in, .phy_mdio_out, .phy_mdio_oe);
    mii_phy_model phy (.phy_tx_en, .phy_txd, .phy_mdio_out, .phy_mdio_oe, .phy_tx_clk,
        .phy_rx_clk, .phy_rxd, .phy_rx_dv, .phy_rx_er, .phy_crs, .phy_col, .phy_mdio_in);
    // Clock and hang guard
    initial forever #20 mclk = ~mclk;
    always @(posedge mclk) if (++cyc == 20000) begin
        bad_count++;
        final_report();
    end
    task chk(input logic [3:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Offer a nibble, held until taken
    task tx_put(input logic [3:0] d);
        mac_tx_data = d;
        mac_tx_valid = 1'b1;
        while (!mac_tx_ready) @(negedge mclk);
        @(negedge mclk);
    endtask
    task rx_get(input logic [3:0] exp);
        while (!mac_rx_valid) @(negedge mclk);
        chk(mac_rx_data, exp);
        mac_rx_ready = 1'b1;
        @(negedge mclk);
        mac_rx_ready = 1'b0;
        // Let an edge pass so a following call never re-raises ready at once
        @(negedge mclk);
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        repeat (6) @(negedge mclk);
        chk(4'(ext_phy_present_strap), 4'h0);
        // Internal PHY: buffer fills and refuses, pins parked
        tx_put(4'h3);
        tx_put(4'h5);
        chk(4'(mac_tx_ready), 4'h0);
        mac_tx_valid = 1'b0;
        phy.phy_crs = 1'b1;
        phy.phy_col = 1'b1;
        phy.phy_rx_er = 1'b1;
        repeat (20) @(negedge mclk);
        chk(phy_txd, 4'h0);
        chk(4'(phy_tx_en), 4'h0);
        chk({1'b0, mac_crs, mac_col, mac_rx_err}, 4'h0);
        ext_phy_sel = 1'b1;
        while (phy.got.size() < 2) @(negedge mclk);
        chk(phy.got.pop_front(), 4'h3);
        chk(phy.got.pop_front(), 4'h5);
        chk({1'b0, mac_crs, mac_col, mac_rx_err}, 4'h7);
        phy.phy_crs = 1'b0;
        phy.phy_col = 1'b0;
        phy.phy_rx_er = 1'b0;
        $display("park and refusal done");
        // Ordinary rows out and back
        for (i = 0; i < 4; i++) begin
            tx_put(rows[i][7:4]);
            mac_tx_valid = 1'b0;
            while (phy.got.size() == 0) @(negedge mclk);
            chk(phy.got.pop_front(), rows[i][3:0]);
            phy.rx_nib(rows[i][7:4]);
            @(negedge mclk);
            rx_get(rows[i][3:0]);
        end
        chk(4'(phy.got.size()), 4'h0);
        $display("rows done");
        // Receiver stall: two nibbles wait in the buffer
        phy.rx_nib(4'h9);
        phy.rx_nib(4'h6);
        @(negedge mclk);
        rx_get(4'h9);
        rx_get(4'h6);
        $display("rx stall done");
        // Clock enable low: a nibble offered meanwhile is never taken
        ce = 1'b0;
        phy.rx_nib(4'hc);
        repeat (4) @(negedge mclk);
        chk(4'(mac_rx_valid), 4'h0);
        ce = 1'b1;
        repeat (20) @(negedge mclk);
        chk(4'(mac_rx_valid), 4'h0);
        $display("freeze done");
        // Management pins routed out, then parked
        mgmt_port_select = 1'b1;
        mac_mgmt_oe = 1'b1;
        mac_mgmt_out = 1'b1;
        repeat (30) @(negedge mclk);
        chk({phy_mdio_oe, phy_mdio_out, mac_mgmt_in}, 3'h7);
        mdc_was = phy_mdc;
        repeat (5) @(negedge mclk);
        chk({3'h0, phy_mdc}, {3'h0, ~mdc_was});
        mgmt_port_select = 1'b0;
        repeat (3) @(negedge mclk);
        chk({phy_mdio_oe, phy_mdc}, 2'h0);
        $display("management done");
        // Second reset with strap high and port select on
        phy.strap = 1'b1;
        mgmt_port_select = 1'b1;
        mac_mgmt_out = 1'b0;
        nrst = 1'b0;
        repeat (3) @(negedge mclk);
        nrst = 1'b1;
        repeat (8) @(negedge mclk);
        chk(4'(ext_phy_present_strap), 4'h1);
        $display("strap done");
        final_report();
    end
endmodule // testbench
bind mii_port_mux mii_port_assertions chk_i (.mclk, .nrst, .ext_phy_sel, .mgmt_port_select,
    .mac_mgmt_out, .phy_txd, .phy_tx_en, .phy_mdc, .phy_mdio_out, .phy_mdio_oe);
